// [core/wdsw_regs.svh]
// Register offsets, field positions, reset values and timing counts for the watchdog block
// Included by the package user files; definitions only
`ifndef WDSW_REGS_SVH
`define WDSW_REGS_SVH
`define WDSW_BANK_F 4'hf
`define WDSW_OFF_WAKE_CTRL 4'hb
`define WDSW_OFF_WAKE_SEL 4'hd
`define WDSW_OFF_WD_MODE 4'hf
`define WDSW_WD_TAP_LO 0
`define WDSW_WD_TAP_HI 1
`define WDSW_WD_HALT_BIT 2
`define WDSW_WD_STOP_BIT 3
`define WDSW_SEL_SRC_LO 2
`define WDSW_SEL_SRC_HI 4
`define WDSW_SEL_LEVEL_BIT 6
`define WDSW_WD_MODE_RST 8'h0d
`define WDSW_WAKE_SEL_RST 8'h00
`define WDSW_LOCK_CYCLES 60
`define WDSW_LOCK_OSC 120
`define WDSW_TAP0 4'h3
`define WDSW_TAP1 4'h5
`define WDSW_TAP2 4'h7
`define WDSW_TAP3 4'h9
`endif

// [core/wdsw_pkg.sv]
// Types shared by the watchdog and stop-wake block
// No surroundings assumed
package wdsw_pkg;
  typedef enum logic [1:0] {
    WDSW_IDLE = 2'b00,
    WDSW_RUN = 2'b01,
    WDSW_FIRE = 2'b10
  } wdsw_state_type;
  typedef enum logic [2:0] {
    WDSW_SRC_POR = 3'b000,
    WDSW_SRC_NAND_P2LO = 3'b001,
    WDSW_SRC_NAND_P2 = 3'b010,
    WDSW_SRC_NOR_P3 = 3'b011,
    WDSW_SRC_NAND_P3 = 3'b100,
    WDSW_SRC_NOR_P3P0 = 3'b101,
    WDSW_SRC_NAND_P3P0 = 3'b110,
    WDSW_SRC_NAND_P3P2 = 3'b111
  } wdsw_src_type;
endpackage

// [core/wdsw_wake.sv]
// Stop-mode wake detector: gate combination of port pins per source select
// Assumes pin levels and direction bits synchronous to core_clk_i
`timescale 1ns/1ps
`include "wdsw_regs.svh"
module wdsw_wake (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic nrst_i,
  // Selection
  input wire logic [2:0] src_i,
  input wire logic level_i,
  // Pins, direction 1 = output
  input wire logic [7:0] p0_i,
  input wire logic [7:0] p0_out_i,
  input wire logic [7:0] p2_i,
  input wire logic [7:0] p2_out_i,
  input wire logic [7:0] p3_i,
  input wire logic [7:0] p3_out_i,
  // Result
  output logic wake_o
);
  // Output pins are removed: they neither force nor block the gate
  function automatic logic nand_g(input logic [7:0] v, input logic [7:0] use_m);
    nand_g = ~&(v | ~use_m);
  endfunction
  function automatic logic nor_g(input logic [7:0] v, input logic [7:0] use_m);
    nor_g = ~|(v & use_m);
  endfunction
  logic gate;
  logic [7:0] m0, m2, m3;
  always_comb begin
    m0 = ~p0_out_i;
    m2 = ~p2_out_i;
    m3 = ~p3_out_i;
    case (wdsw_pkg::wdsw_src_type'(src_i))
      wdsw_pkg::WDSW_SRC_NAND_P2LO: gate = nand_g(p2_i, m2 & 8'h0f);
      wdsw_pkg::WDSW_SRC_NAND_P2: gate = nand_g(p2_i, m2);
      wdsw_pkg::WDSW_SRC_NOR_P3: gate = nor_g(p3_i, m3 & 8'h0e);
      wdsw_pkg::WDSW_SRC_NAND_P3: gate = nand_g(p3_i, m3 & 8'h0e);
      wdsw_pkg::WDSW_SRC_NOR_P3P0:
        gate = ~(~nor_g(p3_i, m3 & 8'h0e) | ~nor_g(p0_i, m0 & 8'h81));
      wdsw_pkg::WDSW_SRC_NAND_P3P0:
        gate = nand_g(p3_i, m3 & 8'h0e) | nand_g(p0_i, m0 & 8'h81);
      wdsw_pkg::WDSW_SRC_NAND_P3P2:
        gate = nand_g(p3_i, m3 & 8'h0e) | nand_g(p2_i, m2 & 8'h07);
      default: gate = 1'b0;
    endcase
  end
  // Low level (0) wakes on gate low, inverted sense; level 1 wakes on gate output high
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wake_o <= 1'b0;
    end else if (src_i == 3'b000) begin
      wake_o <= 1'b0;
    end else begin
      wake_o <= level_i ? gate : ~gate;
    end
  end
endmodule

// [core/wdsw_top.sv]
// Assumes a synchronous single-cycle register port from the core and an RC tick input.
`timescale 1ns/1ps
`include "wdsw_regs.svh"
module wdsw_top (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic nrst_i,
  // Register port
  input wire logic [3:0] reg_bank_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  // Core status
  input wire logic first_instr_i,
  input wire logic refresh_i,
  input wire logic halt_i,
  input wire logic stop_i,
  input wire logic rc_tick_i,
  output logic flag_upd_o,
  output logic flag_z_o,
  output logic flag_s_o,
  output logic flag_v_o,
  // Ports
  input wire logic [7:0] p0_i,
  input wire logic [7:0] p0_out_i,
  input wire logic [7:0] p2_i,
  input wire logic [7:0] p2_out_i,
  input wire logic [7:0] p3_i,
  input wire logic [7:0] p3_out_i,
  // Results
  output logic wake_o,
  output logic wd_reset_o,
  output logic wd_active_o
);
  logic [7:0] wd_mode_reg;
  logic [7:0] wake_sel_reg;
  logic [6:0] lock_cnt_reg;
  logic open_reg;
  logic [9:0] wd_cnt_reg;
  wdsw_pkg::wdsw_state_type state_reg;
  logic wr_mode, wr_sel, tick, terminal;

  function automatic logic hit(input logic [3:0] bank, input logic [3:0] off,
                               input logic [3:0] a);
    hit = (bank == `WDSW_BANK_F) && (a == off);
  endfunction

  assign wr_mode = reg_wr_i && hit(reg_bank_i, `WDSW_OFF_WD_MODE, reg_addr_i);
  assign wr_sel = reg_wr_i && hit(reg_bank_i, `WDSW_OFF_WAKE_SEL, reg_addr_i);

  // Write window: opens at first instruction, closes after the cycle count
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      open_reg <= 1'b0;
      lock_cnt_reg <= 7'h00;
    end else if (first_instr_i) begin
      open_reg <= 1'b1;
      lock_cnt_reg <= 7'h00;
    end else if (open_reg) begin
      lock_cnt_reg <= lock_cnt_reg + 7'h01;
      if (lock_cnt_reg == 7'(`WDSW_LOCK_CYCLES - 1)) begin
        open_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wd_mode_reg <= `WDSW_WD_MODE_RST;
    end else if (wr_mode && open_reg) begin
      wd_mode_reg <= {4'h0, reg_wdata_i[3:0]};
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wake_sel_reg <= `WDSW_WAKE_SEL_RST;
    end else if (wr_sel) begin
      wake_sel_reg <= reg_wdata_i & 8'h5c;
    end
  end

  // The wake select register and the mode register are write-only
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      reg_rdata_o <= 8'h00;
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end

  // Counter advances on RC ticks unless halt or stop gating forbids it
  assign tick = rc_tick_i
    && !(halt_i && !wd_mode_reg[`WDSW_WD_HALT_BIT])
    && !(stop_i && !wd_mode_reg[`WDSW_WD_STOP_BIT]);

  always_comb begin
    case (wd_mode_reg[`WDSW_WD_TAP_HI:`WDSW_WD_TAP_LO])
      2'b00: terminal = wd_cnt_reg[`WDSW_TAP0];
      2'b01: terminal = wd_cnt_reg[`WDSW_TAP1];
      2'b10: terminal = wd_cnt_reg[`WDSW_TAP2];
      default: terminal = wd_cnt_reg[`WDSW_TAP3];
    endcase
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_reg <= wdsw_pkg::WDSW_IDLE;
      wd_cnt_reg <= 10'h000;
    end else begin
      case (state_reg)
        wdsw_pkg::WDSW_IDLE: begin
          if (refresh_i) begin
            state_reg <= wdsw_pkg::WDSW_RUN;
          end
          wd_cnt_reg <= 10'h000;
        end
        wdsw_pkg::WDSW_RUN: begin
          if (refresh_i) begin
            wd_cnt_reg <= 10'h000;
          end else if (terminal) begin
            state_reg <= wdsw_pkg::WDSW_FIRE;
          end else if (tick) begin
            wd_cnt_reg <= wd_cnt_reg + 10'h001;
          end
        end
        wdsw_pkg::WDSW_FIRE: begin
          state_reg <= wdsw_pkg::WDSW_IDLE;
          wd_cnt_reg <= 10'h000;
        end
        default: state_reg <= wdsw_pkg::WDSW_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wd_reset_o <= 1'b0;
      wd_active_o <= 1'b0;
    end else begin
      wd_reset_o <= (state_reg == wdsw_pkg::WDSW_RUN) && terminal && !refresh_i;
      wd_active_o <= (state_reg == wdsw_pkg::WDSW_RUN) || refresh_i;
    end
  end

  // Flag image of a refresh: zero set, sign and overflow cleared
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      flag_upd_o <= 1'b0;
      flag_z_o <= 1'b0;
      flag_s_o <= 1'b0;
      flag_v_o <= 1'b0;
    end else begin
      flag_upd_o <= refresh_i;
      flag_z_o <= refresh_i;
      flag_s_o <= 1'b0;
      flag_v_o <= 1'b0;
    end
  end

  wdsw_wake wdsw_wake_i (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .src_i(wake_sel_reg[`WDSW_SEL_SRC_HI:`WDSW_SEL_SRC_LO]),
    .level_i(wake_sel_reg[`WDSW_SEL_LEVEL_BIT]),
    .p0_i(p0_i),
    .p0_out_i(p0_out_i),
    .p2_i(p2_i),
    .p2_out_i(p2_out_i),
    .p3_i(p3_i),
    .p3_out_i(p3_out_i),
    .wake_o(wake_o)
  );

  property p_lock_after_window;
    @(posedge core_clk_i) disable iff (!nrst_i)
      (!open_reg && wr_mode) |=> $stable(wd_mode_reg);
  endproperty
  a_lock_after_window: assert property (p_lock_after_window) else $error("mode changed when locked");
  property p_window_len;
    @(posedge core_clk_i) disable iff (!nrst_i)
      $rose(open_reg) |-> open_reg [*8];
  endproperty
  a_window_len: assert property (p_window_len) else $error("window closed early");
  property p_reserved;
    @(posedge core_clk_i) disable iff (!nrst_i) wd_mode_reg[7:4] == 4'h0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved mode bits set");
  property p_read_zero;
    @(posedge core_clk_i) disable iff (!nrst_i) reg_rd_i |=> reg_rdata_o == 8'h00;
  endproperty
  a_read_zero: assert property (p_read_zero) else $error("mode register readable");
  property p_idle_quiet;
    @(posedge core_clk_i) disable iff (!nrst_i)
      (state_reg == wdsw_pkg::WDSW_IDLE && !refresh_i) |=> !wd_reset_o;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("reset while idle");
  property p_fire;
    @(posedge core_clk_i) disable iff (!nrst_i)
      (state_reg == wdsw_pkg::WDSW_RUN && terminal && !refresh_i) |=> wd_reset_o;
  endproperty
  a_fire: assert property (p_fire) else $error("terminal count missed");
  property p_restart;
    @(posedge core_clk_i) disable iff (!nrst_i)
      (state_reg == wdsw_pkg::WDSW_RUN && refresh_i) |=> wd_cnt_reg == 10'h000;
  endproperty
  a_restart: assert property (p_restart) else $error("refresh did not restart");
  property p_halt_hold;
    @(posedge core_clk_i) disable iff (!nrst_i)
      (halt_i && !wd_mode_reg[`WDSW_WD_HALT_BIT] && !refresh_i && state_reg == wdsw_pkg::WDSW_RUN
       && !terminal) |=> $stable(wd_cnt_reg);
  endproperty
  a_halt_hold: assert property (p_halt_hold) else $error("counted in halt");
  property p_flags;
    @(posedge core_clk_i) disable iff (!nrst_i) refresh_i |=> flag_upd_o && flag_z_o;
  endproperty
  a_flags: assert property (p_flags) else $error("flags not updated");
  c_fire: cover property (@(posedge core_clk_i) disable iff (!nrst_i) wd_reset_o);
  c_mode_wr: cover property (@(posedge core_clk_i) disable iff (!nrst_i) wr_mode && open_reg);
  c_wake: cover property (@(posedge core_clk_i) disable iff (!nrst_i) wake_o);
endmodule

// [sim/wdsw_core_model.sv]
// Core side model: first-instruction and refresh pulses, free RC tick
// Assumes requests from the bench arrive as one-cycle pulses on core_clk_i
`timescale 1ns/1ps
module wdsw_core_model #(
  parameter int TICK_DIV = 2
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic nrst_i,
  // Requests
  input wire logic first_req_i,
  input wire logic kick_req_i,
  // To block
  output logic first_instr_o,
  output logic refresh_o,
  output logic rc_tick_o
);
  logic [3:0] div_reg;
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      div_reg <= 4'h0;
      rc_tick_o <= 1'b0;
    end else begin
      div_reg <= (div_reg == 4'(TICK_DIV - 1)) ? 4'h0 : div_reg + 4'h1;
      rc_tick_o <= (div_reg == 4'(TICK_DIV - 1));
    end
  end
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      first_instr_o <= 1'b0;
      refresh_o <= 1'b0;
    end else begin
      first_instr_o <= first_req_i;
      refresh_o <= kick_req_i;
    end
  end
endmodule

// [sim/watchdog_and_stop_wake_select_tb_top.sv]
// Self-checking bench for the watchdog and stop-wake block
// Assumes the core model ticks the RC input every second cycle
`timescale 1ns/1ps
module watchdog_and_stop_wake_select_tb_top;
  logic core_clk_i = 1'b0, nrst_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
  logic first_req = 1'b0, kick_req = 1'b0, halt_i = 1'b0, stop_i = 1'b0;
  logic [3:0] reg_bank_i = 4'h0, reg_addr_i = 4'h0;
  logic [7:0] reg_wdata_i = 8'h00, pv = 8'h00, po = 8'h00, reg_rdata_o;
  logic first_instr, refresh, rc_tick, flag_upd_o, flag_z_o, flag_s_o, flag_v_o;
  logic wake_o, wd_reset_o, wd_active_o;
  int errors = 0, comparisons = 0, fires = 0;
  always #20 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) if (wd_reset_o === 1'b1) fires++;
  wdsw_core_model #(.TICK_DIV(2)) wdsw_core_model_i (.core_clk_i(core_clk_i),
    .nrst_i(nrst_i), .first_req_i(first_req), .kick_req_i(kick_req),
    .first_instr_o(first_instr), .refresh_o(refresh), .rc_tick_o(rc_tick));
  wdsw_top wdsw_top_i (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .reg_bank_i(reg_bank_i),
    .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .first_instr_i(first_instr),
    .refresh_i(refresh), .halt_i(halt_i), .stop_i(stop_i), .rc_tick_i(rc_tick),
    .flag_upd_o(flag_upd_o), .flag_z_o(flag_z_o), .flag_s_o(flag_s_o),
    .flag_v_o(flag_v_o), .p0_i(pv), .p0_out_i(po), .p2_i(pv), .p2_out_i(po), .p3_i(pv),
    .p3_out_i(po), .wake_o(wake_o), .wd_reset_o(wd_reset_o), .wd_active_o(wd_active_o));
  task automatic finish_test();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    comparisons++;
    if (s !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask
  task automatic wr(input logic [3:0] b, input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    reg_bank_i <= b;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd_chk(input logic [3:0] a);
    @(posedge core_clk_i);
    reg_bank_i <= 4'hf;
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    cyc(1);
    #1 chk("rdata", reg_rdata_o, 8'h00);
  endtask
  task automatic do_reset();
    @(posedge core_clk_i);
    nrst_i <= 1'b0;
    cyc(20);
    nrst_i <= 1'b1;
    cyc(2);
    first_req <= 1'b1;
    cyc(1);
    first_req <= 1'b0;
    cyc(1);
  endtask
  task automatic kick();
    @(posedge core_clk_i);
    kick_req <= 1'b1;
    @(posedge core_clk_i);
    kick_req <= 1'b0;
  endtask
  // Refresh, then see whether the reset comes near 2*ticks cycles
  task automatic expire(input int ticks, input logic fire);
    int n;
    logic ok;
    n = 0;
    kick();
    while (wd_reset_o !== 1'b1 && n < 2 * ticks + 8) begin
      @(posedge core_clk_i);
      n++;
    end
    ok = fire ? (wd_reset_o === 1'b1 && n >= 2 * ticks - 4) : (wd_reset_o !== 1'b1);
    chk("wd_timeout", {7'h0, ok}, 8'h01);
  endtask
  function automatic logic wexp(input logic [2:0] s, input logic l, input logic [7:0] v,
                                input logic [7:0] o);
    logic [7:0] a;
    logic [7:0] r;
    logic g;
    a = v | o;
    r = v & ~o;
    case (s)
      3'h1: g = ~&a[3:0];
      3'h2: g = ~&a;
      3'h3: g = ~|r[3:1];
      3'h4: g = ~&a[3:1];
      3'h5: g = ~|{r[3:1], r[0], r[7]};
      3'h6: g = ~&{a[3:1], a[0], a[7]};
      3'h7: g = ~&{a[3:1], a[2:0]};
      default: return 1'b0;
    endcase
    return l ? g : ~g;
  endfunction
  task automatic t_taps();
    for (int t = 0; t < 4; t++) begin
      do_reset();
      wr(4'hf, 4'hf, 8'hf0 | 8'(t));
      wr(4'h0, 4'hf, 8'(~t & 3));
      cyc(30);
      chk("idle", {7'h0, wd_active_o | wd_reset_o}, 8'h00);
      expire(8 << (2 * t), 1'b1);
    end
    rd_chk(4'hf);
    rd_chk(4'h3);
    $display("test taps done");
  endtask
  task automatic t_lock();
    do_reset();
    cyc(62);
    wr(4'hf, 4'hf, 8'h00);
    expire(32, 1'b1);
    // Last open edge takes a write, the next write is refused
    do_reset();
    cyc(58);
    wr(4'hf, 4'hf, 8'h00);
    wr(4'hf, 4'hf, 8'h03);
    expire(8, 1'b1);
    $display("test lock done");
  endtask
  task automatic t_refresh();
    int f;
    do_reset();
    kick();
    cyc(1);
    #1 chk("flags", {flag_upd_o, flag_z_o, flag_s_o, flag_v_o, wd_active_o}, 8'h19);
    f = fires;
    repeat (6) begin
      cyc(40);
      kick();
    end
    chk("restart", 8'(fires - f), 8'h00);
    $display("test refresh done");
  endtask
  task automatic t_lowpower();
    for (int i = 0; i < 3; i++) begin
      do_reset();
      wr(4'hf, 4'hf, i == 0 ? 8'h09 : (i == 1 ? 8'h05 : 8'h0d));
      halt_i <= (i != 1);
      stop_i <= (i == 1);
      expire(32, 1'(i == 2));
      halt_i <= 1'b0;
      stop_i <= 1'b0;
    end
    $display("test lowpower done");
  endtask
  task automatic t_wake();
    logic [15:0] pat [6] = '{16'hff00, 16'h0000, 16'hfe01, 16'h8100, 16'h0e00, 16'h0f00};
    logic e;
    do_reset();
    for (int s = 0; s < 8; s++) begin
      for (int l = 0; l < 2; l++) begin
        wr(4'hf, 4'hd, {1'b0, 1'(l), 1'b0, 3'(s), 2'b00});
        for (int p = 0; p < 6; p++) begin
          pv <= pat[p][15:8];
          po <= pat[p][7:0];
          cyc(3);
          e = wexp(3'(s), 1'(l), pat[p][15:8], pat[p][7:0]);
          chk("wake", {7'h0, wake_o}, {7'h0, e});
        end
      end
    end
    $display("test wake done");
  endtask
  initial begin
    do_reset();
    chk("post_reset", {6'h0, wd_active_o, wake_o}, 8'h00);
    t_taps();
    t_lock();
    t_refresh();
    t_lowpower();
    t_wake();
    finish_test();
  end
  initial begin
    cyc(20000);
    errors++;
    finish_test();
  end
endmodule
